// File: verilog/ctu_pkg.sv
// package: register map, instruction fields, cycle codes for the transfer unit
package ctu_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTU_OFS_CTRL = 8'h00;
  localparam logic [7:0] CTU_OFS_INSTR = 8'h04;
  localparam logic [7:0] CTU_OFS_BASE = 8'h08;
  localparam logic [7:0] CTU_OFS_SRC = 8'h0c;
  localparam logic [7:0] CTU_OFS_PC = 8'h10;
  localparam logic [7:0] CTU_OFS_FLAGS = 8'h14;
  localparam logic [7:0] CTU_OFS_STATUS = 8'h18;
  localparam logic [7:0] CTU_OFS_RESULT = 8'h1c;
  localparam logic [7:0] CTU_OFS_WORDS = 8'h20;
  localparam logic [31:0] CTU_RST_WORD = 32'h0000_0000;

  // control and status bit positions
  localparam int CTU_CTRL_START = 0;
  localparam int CTU_ST_BUSY = 0;
  localparam int CTU_ST_DONE = 1;
  localparam int CTU_ST_SKIP = 2;
  localparam int CTU_ST_ABSENT = 3;
  localparam int CTU_ST_ABORT = 4;
  localparam int CTU_ST_W = 5;

  // ==========================================================
  // instruction fields
  localparam int CTU_F_COND = 28;
  localparam int CTU_F_CLS3 = 25;
  localparam int CTU_F_CLS4 = 24;
  localparam int CTU_F_P = 24;
  localparam int CTU_F_U = 23;
  localparam int CTU_F_W = 21;
  localparam int CTU_F_L = 20;
  localparam int CTU_F_RN = 16;
  localparam int CTU_F_RD = 12;
  localparam int CTU_F_REGBIT = 4;
  localparam int CTU_F_FLAGS = 28;
  localparam logic [2:0] CTU_CLS_BLOCK = 3'h6;
  localparam logic [3:0] CTU_CLS_REG = 4'he;
  localparam logic [3:0] CTU_PC_REG = 4'hf;
  localparam logic [31:0] CTU_PC_BASE_ADJ = 32'h0000_0008;
  localparam logic [31:0] CTU_PC_SRC_ADJ = 32'h0000_000c;
  localparam logic [31:0] CTU_WORD_STEP = 32'h0000_0004;

  // ==========================================================
  // bus cycle codes as {mem_request_low, sequential_flag}
  typedef enum logic [1:0] {
    CTU_CYC_N = 2'h0,
    CTU_CYC_S = 2'h1,
    CTU_CYC_I = 2'h2,
    CTU_CYC_C = 2'h3
  } ctu_cycle_e;

  localparam logic [1:0] CTU_RESP_OKAY = 2'h0;
  localparam logic [1:0] CTU_RESP_SLVERR = 2'h2;

  function automatic logic [31:0] ctu_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : ctu_merge

endpackage : ctu_pkg

// File: verilog/ctu_reg_if.sv
// interface: register access strobes between bus slave and core
`timescale 1ns/10ps
`default_nettype none
interface ctu_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : ctu_reg_if
`default_nettype wire

// File: verilog/ctu_axil_slave.sv
// module: AXI4-Lite slave feeding the register strobes
`timescale 1ns/10ps
`default_nettype none
module ctu_axil_slave
  (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  ctu_reg_if.bus rif
  );
  import ctu_pkg::*;

  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic ar_take;

  // ==========================================================
  // handshakes
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rif.wr_en = do_write;
  assign rif.wr_addr = aw_addr_reg;
  assign rif.wr_data = w_data_reg;
  assign rif.wr_strb = w_strb_reg;
  assign rif.rd_addr = s_axi_araddr;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= CTU_RST_WORD;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CTU_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= CTU_RST_WORD;
      s_axi_rresp <= CTU_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_full_reg <= 1'b0;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= rif.wr_ok ? CTU_RESP_OKAY : CTU_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rif.rd_data;
        s_axi_rresp <= rif.rd_ok ? CTU_RESP_OKAY : CTU_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ctu_axil_slave
`default_nettype wire

// File: verilog/ctu_decode.sv
// module: condition check, class decode and block address arithmetic
`timescale 1ns/10ps
`default_nettype none
module ctu_decode
  (
  // instruction and core state
  input wire logic [31:0] instr,
  input wire logic [3:0] flags,
  input wire logic [31:0] base_value,
  input wire logic [31:0] pc_value,
  // decode results
  output logic cond_pass,
  output logic is_block,
  output logic is_reg,
  output logic [31:0] first_addr,
  output logic [31:0] mod_base
  );
  import ctu_pkg::*;

  logic n_f;
  logic z_f;
  logic c_f;
  logic v_f;
  logic [3:0] cond;
  logic [7:0] cond_pairs;
  logic [31:0] base_eff;
  logic [31:0] offset;

  assign {n_f, z_f, c_f, v_f} = flags;
  assign cond = instr[CTU_F_COND +: 4];
  // even codes test, odd codes invert; last pair is always / never
  assign cond_pairs = {1'b1, !z_f && (n_f == v_f), n_f == v_f, c_f && !z_f,
                       v_f, n_f, c_f, z_f};
  assign cond_pass = cond_pairs[cond[3:1]] ^ cond[0]; // see RL1
  assign is_block = instr[CTU_F_CLS3 +: 3] == CTU_CLS_BLOCK;
  assign is_reg = (instr[CTU_F_CLS4 +: 4] == CTU_CLS_REG) && instr[CTU_F_REGBIT];

  // ==========================================================
  // addressing
  assign base_eff = (instr[CTU_F_RN +: 4] == CTU_PC_REG) ? pc_value + CTU_PC_BASE_ADJ
                                                        : base_value; // see RL11
  assign offset = {22'h00_0000, instr[7:0], 2'h0}; // see RL5
  assign mod_base = instr[CTU_F_U] ? base_eff + offset : base_eff - offset; // see RL5
  // low address bits pass untouched, no alignment forced
  assign first_addr = instr[CTU_F_P] ? mod_base : base_eff; // see RL6 see RL10

endmodule : ctu_decode
`default_nettype wire

// File: verilog/ctu_top.sv
// module: coprocessor transfer unit, sequencer and register file
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1 - failed condition does nothing
// RL2 - core addresses, coprocessor moves data
// RL3 - coprocessor answers own number only
// RL4 - length bit picks transfer length
// RL5 - offset imm8 times four, up/down
// RL6 - pre-index offsets first address
// RL7 - write-back only with W set
// RL8 - no implicit post-index write-back
// RL9 - next word one word higher
// RL10 - low address bits unaltered
// RL11 - pc base is address plus 8
// RL12 - abort flagged, write-back kept
// RL13 - coprocessor actions stay repeatable
// RL14 - block: (n-1)S, 2N, bI cycles
// RL15 - load-to-pc sets four flags
// RL16 - pc source sends pc+12
// RL17 - register move cycle counts
// RL18 - direction bit: set loads core
// RL19 - coprocessor interprets register fields
// RL20 - dest field names first register
// RL21 - coprocessor numbers zero to fifteen
// RL22 - refusal raises absent and busy
// RL23 - cycle type on request lines
// RL24 - busy stalls with internal cycles
// RL25 - word crosses bus in C-cycle
module ctu_top
  (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory side
  output logic [31:0] mem_addr,
  output logic mem_request_low,
  output logic sequential_flag,
  output logic mem_write,
  input wire logic mem_abort,
  // shared data bus
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe,
  // coprocessor handshake
  output logic [31:0] cp_instr,
  output logic cp_offer,
  input wire logic coproc_absent,
  input wire logic coproc_busy,
  input wire logic cp_last_word
  );
  import ctu_pkg::*;

  typedef enum logic [2:0] {CTU_IDLE, CTU_OFFER, CTU_XFER, CTU_EXTRA, CTU_CCYC, CTU_FIN} ctu_state_e;

  ctu_reg_if rif();

  ctu_state_e state_reg, state_next;
  ctu_cycle_e cyc_reg, cyc_next;
  logic [31:0] instr_reg, base_value_reg, src_reg, pc_reg, result_reg, addr_reg, addr_next, dout_reg;
  logic [3:0] flags_reg;
  logic [15:0] words_reg;
  logic write_reg, done_reg, skip_reg, absent_reg, abort_reg;

  logic cond_pass, is_block, is_reg;
  logic [31:0] first_addr, mod_base;

  ctu_axil_slave u_bus (.*, .rif(rif.bus));

  ctu_decode u_dec (.instr(instr_reg), .flags(flags_reg), .base_value(base_value_reg), .pc_value(pc_reg),
    .cond_pass(cond_pass), .is_block(is_block), .is_reg(is_reg), .first_addr(first_addr), .mod_base(mod_base));

  // ==========================================================
  // register decode
  wire idle = state_reg == CTU_IDLE;
  wire wr_ctrl = rif.wr_en && rif.wr_addr == CTU_OFS_CTRL;
  wire wr_instr = rif.wr_en && rif.wr_addr == CTU_OFS_INSTR;
  wire wr_base = rif.wr_en && rif.wr_addr == CTU_OFS_BASE;
  wire wr_src = rif.wr_en && rif.wr_addr == CTU_OFS_SRC;
  wire wr_pc = rif.wr_en && rif.wr_addr == CTU_OFS_PC;
  wire wr_flags = rif.wr_en && rif.wr_addr == CTU_OFS_FLAGS;
  wire wr_status = rif.wr_en && rif.wr_addr == CTU_OFS_STATUS;
  // instruction fields are frozen while a transfer runs
  wire start = wr_ctrl && rif.wr_strb[0] && rif.wr_data[CTU_CTRL_START] && idle;
  wire done_clr = wr_status && rif.wr_strb[0] && rif.wr_data[CTU_ST_DONE];
  wire load_dir = instr_reg[CTU_F_L]; // see RL18
  wire pc_is_rd = instr_reg[CTU_F_RD +: 4] == CTU_PC_REG;
  wire [31:0] next_fetch = pc_reg + CTU_WORD_STEP;
  wire [31:0] core_word = pc_is_rd ? pc_reg + CTU_PC_SRC_ADJ : src_reg; // see RL16
  wire accepted = state_reg == CTU_OFFER && !coproc_absent && !coproc_busy;
  wire refused = state_reg == CTU_OFFER && coproc_absent; // see RL22
  wire blk_end = state_reg == CTU_XFER && (mem_abort || cp_last_word); // see RL2
  wire wback_now = blk_end && instr_reg[CTU_F_W]; // see RL7 see RL8 see RL12
  wire mrc_take = state_reg == CTU_CCYC && load_dir;
  wire finish = state_reg == CTU_FIN || refused || (start && !(cond_pass && (is_block || is_reg)));
  wire [CTU_ST_W-1:0] status_bits = {abort_reg, absent_reg, skip_reg, done_reg, !idle};

  assign rif.wr_ok = wr_ctrl || wr_instr || wr_base || wr_src || wr_pc || wr_flags || wr_status;
  assign rif.rd_ok = rif.rd_addr <= CTU_OFS_WORDS && rif.rd_addr[1:0] == 2'h0;
  assign rif.rd_data = (rif.rd_addr == CTU_OFS_INSTR) ? instr_reg
                     : (rif.rd_addr == CTU_OFS_BASE) ? base_value_reg
                     : (rif.rd_addr == CTU_OFS_SRC) ? src_reg
                     : (rif.rd_addr == CTU_OFS_PC) ? pc_reg
                     : (rif.rd_addr == CTU_OFS_FLAGS) ? {28'h000_0000, flags_reg}
                     : (rif.rd_addr == CTU_OFS_STATUS) ? {27'h000_0000, status_bits}
                     : (rif.rd_addr == CTU_OFS_RESULT) ? result_reg
                     : (rif.rd_addr == CTU_OFS_WORDS) ? {16'h0000, words_reg}
                     : CTU_RST_WORD;

  // ==========================================================
  // pins
  assign {mem_request_low, sequential_flag} = cyc_reg; // see RL23
  assign mem_addr = addr_reg;
  assign mem_write = write_reg;
  assign data_out = dout_reg;
  assign data_oe = state_reg == CTU_CCYC && !load_dir; // see RL25
  assign cp_instr = instr_reg;
  // coprocessor matches its own number itself
  assign cp_offer = state_reg == CTU_OFFER; // see RL3 see RL21

  // ==========================================================
  // sequencer
  always_comb
  begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    addr_next = addr_reg;
    unique case (state_reg)
      CTU_IDLE:
      begin
        cyc_next = CTU_CYC_I;
        if (start && cond_pass && (is_block || is_reg)) // see RL1
          state_next = CTU_OFFER;
      end
      CTU_OFFER:
      begin
        cyc_next = CTU_CYC_I; // see RL24
        if (refused)
          state_next = CTU_IDLE;
        else if (accepted && is_block)
        begin
          state_next = CTU_XFER;
          cyc_next = CTU_CYC_N; // see RL14
          addr_next = first_addr; // see RL2 see RL6
        end
        else if (accepted && load_dir)
          state_next = CTU_EXTRA; // see RL17
        else if (accepted)
        begin
          state_next = CTU_CCYC;
          cyc_next = CTU_CYC_C; // see RL17
        end
      end
      CTU_XFER:
      begin
        if (blk_end)
        begin
          state_next = CTU_FIN;
          cyc_next = CTU_CYC_N; // see RL14
          addr_next = next_fetch;
        end
        else
        begin
          cyc_next = CTU_CYC_S; // see RL14
          addr_next = addr_reg + CTU_WORD_STEP; // see RL9
        end
      end
      CTU_EXTRA:
      begin
        state_next = CTU_CCYC;
        cyc_next = CTU_CYC_C;
      end
      CTU_CCYC:
      begin
        state_next = CTU_FIN;
        cyc_next = CTU_CYC_S; // see RL17
        addr_next = next_fetch;
      end
      CTU_FIN:
      begin
        state_next = CTU_IDLE;
        cyc_next = CTU_CYC_I;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= CTU_IDLE;
      cyc_reg <= CTU_CYC_I;
      addr_reg <= CTU_RST_WORD;
    end
    else
    begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      addr_reg <= addr_next;
    end
  end

  // store direction held for the whole block; memory is write for stores
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      write_reg <= 1'b0;
    else if (accepted && is_block)
      write_reg <= !load_dir; // see RL18
    else if (blk_end)
      write_reg <= 1'b0;
  end

  // word goes out on the bus only in the coprocessor cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dout_reg <= CTU_RST_WORD;
    else if (accepted && is_reg && !load_dir)
      dout_reg <= core_word; // see RL25
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr_reg <= CTU_RST_WORD;
      src_reg <= CTU_RST_WORD;
      pc_reg <= CTU_RST_WORD;
    end
    else if (idle)
    begin
      if (wr_instr)
        instr_reg <= ctu_merge(instr_reg, rif.wr_data, rif.wr_strb);
      if (wr_src)
        src_reg <= ctu_merge(src_reg, rif.wr_data, rif.wr_strb);
      if (wr_pc)
        pc_reg <= ctu_merge(pc_reg, rif.wr_data, rif.wr_strb);
    end
  end

  // write-back holds over a software write in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      base_value_reg <= CTU_RST_WORD;
    else if (wback_now)
      base_value_reg <= mod_base; // see RL7 see RL12
    else if (wr_base)
      base_value_reg <= ctu_merge(base_value_reg, rif.wr_data, rif.wr_strb);
  end

  // only the four flag bits change, pc left alone
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_reg <= 4'h0;
    else if (mrc_take && pc_is_rd)
      flags_reg <= data_in[CTU_F_FLAGS +: 4]; // see RL15
    else if (wr_flags && rif.wr_strb[0])
      flags_reg <= rif.wr_data[3:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      result_reg <= CTU_RST_WORD;
    else if (mrc_take && !pc_is_rd)
      result_reg <= data_in; // see RL25
  end

  // counts words whose cycle ran, the aborted one included
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      words_reg <= 16'h0000;
    else if (start)
      words_reg <= 16'h0000;
    else if (state_reg == CTU_XFER)
      words_reg <= words_reg + 16'h0001;
  end

  // ==========================================================
  // status: done is sticky, a new completion beats the clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
      absent_reg <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      done_reg <= finish || (done_reg && !done_clr);
      if (start)
      begin
        skip_reg <= !cond_pass; // see RL1
        absent_reg <= cond_pass && !(is_block || is_reg);
        abort_reg <= 1'b0;
      end
      else
      begin
        if (refused)
          absent_reg <= 1'b1;
        if (state_reg == CTU_XFER && mem_abort)
          abort_reg <= 1'b1; // see RL12
      end
    end
  end

endmodule : ctu_top
`default_nettype wire

// File: tb/ctu_props.sv
// checker: port-level properties of the transfer unit
`timescale 1ns/10ps
`default_nettype none
module ctu_props
  (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // memory and coprocessor side
  input wire logic [31:0] mem_addr,
  input wire logic mem_request_low,
  input wire logic sequential_flag,
  input wire logic mem_write,
  input wire logic mem_abort,
  input wire logic data_oe,
  input wire logic [31:0] cp_instr,
  input wire logic cp_offer,
  input wire logic coproc_absent,
  input wire logic coproc_busy,
  input wire logic cp_last_word
  );
  import ctu_pkg::*;
  logic [1:0] cyc;
  logic go;
  logic rg;
  assign cyc = {mem_request_low, sequential_flag};
  assign go = cp_offer && !coproc_busy && !coproc_absent;
  assign rg = cp_instr[27:24] == CTU_CLS_REG;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========
  // closing steps
  sequence fin_s;
    cyc == CTU_CYC_N ##1 cyc == CTU_CYC_I;
  endsequence
  sequence tail_s;
    cyc == CTU_CYC_S ##1 cyc == CTU_CYC_I;
  endsequence
  // ==========
  // properties
  oe_in_c_a:
    assert property (data_oe |-> cyc == CTU_CYC_C) else $error("oe outside C");
  addr_step_a:
    assert property (cyc == CTU_CYC_S && $past(cyc) inside {CTU_CYC_N, CTU_CYC_S}
      |-> mem_addr == $past(mem_addr) + 32'h0000_0004) else $error("bad step");
  busy_stall_a:
    assert property (cp_offer && coproc_busy && !coproc_absent |=> cp_offer && cyc == CTU_CYC_I)
      else $error("no stall");
  last_fin_a:
    assert property (cp_last_word && cyc == CTU_CYC_S |=> fin_s) else $error("no finish");
  abort_fin_a:
    assert property (mem_write && mem_abort |=> fin_s) else $error("abort ignored");
  c_tail_a:
    assert property (cyc == CTU_CYC_C |=> tail_s) else $error("bad C tail");
  load_seq_a:
    assert property (go && rg && cp_instr[CTU_F_L] |=> cyc == CTU_CYC_I ##1 cyc == CTU_CYC_C)
      else $error("bad load");
  store_c_a:
    assert property (go && rg && !cp_instr[CTU_F_L] |=> cyc == CTU_CYC_C && data_oe) else $error("bad store");
  blk_go_a:
    assert property (go && cp_instr[27:25] == CTU_CLS_BLOCK
      |=> cyc == CTU_CYC_N && mem_write == !cp_instr[CTU_F_L]) else $error("bad block start");
endmodule : ctu_props
`default_nettype wire

// File: tb/ctu_cp_model.sv
// partner: behavioural coprocessor answering offered transfers
`timescale 1ns/10ps
`default_nettype none
module ctu_cp_model
  #(parameter logic [3:0] MY_NUM = 4'h1)
  (
  // core side
  input wire logic clk,
  input wire logic [31:0] cp_instr,
  input wire logic cp_offer,
  input wire logic mem_request_low,
  input wire logic sequential_flag,
  // scenario controls
  input wire logic [3:0] busy_len,
  input wire logic [3:0] long_len,
  input wire logic [31:0] reply,
  // answers
  output logic coproc_absent,
  output logic coproc_busy,
  output logic cp_last_word,
  output logic [31:0] data_in
  );
  logic [3:0] wait_cnt;
  logic [3:0] word_cnt;
  logic [3:0] len;
  logic mine;
  logic active;
  assign mine = cp_instr[11:8] == MY_NUM;
  assign coproc_absent = cp_offer && !mine;
  assign coproc_busy = cp_offer && (!mine || wait_cnt < busy_len);
  assign len = cp_instr[22] ? long_len : 4'h1;
  assign cp_last_word = active && word_cnt + 4'h1 == len;
  // inverse outside the C-cycle exposes stale samples
  assign data_in = {mem_request_low, sequential_flag} == 2'h3 ? reply : ~reply;
  always_ff @(posedge clk)
  begin
    wait_cnt <= cp_offer ? wait_cnt + 4'h1 : 4'h0;
    // fresh count per offer keeps a retried transfer repeatable
    if (cp_offer && !coproc_busy)
    begin
      active <= 1'b1;
      word_cnt <= 4'h0;
    end
    else if ({mem_request_low, sequential_flag} == 2'h2)
      active <= 1'b0;
    else
      word_cnt <= word_cnt + 4'h1;
  end
endmodule : ctu_cp_model
`default_nettype wire

// File: tb/tb_top.sv
// testbench: scenario tasks driving the transfer unit over its register bus
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
  import ctu_pkg::*;
  logic clk, reset_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, mreq, seqf, mwr, abt, oe, offer, abs, bsy, lw;
  logic [7:0] aa, ra;
  logic [31:0] wd, rd, maddr, din, dout, ins, reply, fa, cw, got;
  logic [1:0] rresp, bresp, resp;
  logic [3:0] blen, llen;
  int n_errors, checks, n_n, n_s, tick;
  ctu_top uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .mem_addr(maddr),
    .mem_request_low(mreq), .sequential_flag(seqf), .mem_write(mwr), .mem_abort(abt), .data_in(din),
    .data_out(dout), .data_oe(oe), .cp_instr(ins), .cp_offer(offer), .coproc_absent(abs),
    .coproc_busy(bsy), .cp_last_word(lw));
  ctu_cp_model #(.MY_NUM(4'h1)) cp (.clk(clk), .cp_instr(ins), .cp_offer(offer), .mem_request_low(mreq),
    .sequential_flag(seqf), .busy_len(blen), .long_len(llen), .reply(reply), .coproc_absent(abs),
    .coproc_busy(bsy), .cp_last_word(lw), .data_in(din));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // cycle tally, taken mid-cycle where outputs are settled
  always @(negedge clk)
  begin
    tick++;
    if (!mreq && !seqf && n_n == 0)
      fa = maddr;
    if (!mreq)
    begin
      if (seqf)
        n_s++;
      else
        n_n++;
    end
    if (oe)
      cw = dout;
    if (tick == 30000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========
  // bus and helpers
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, fin;
    int n;
    @(posedge clk);
    {aa, wd, awv, wv, br} <= w ? {a, d, 3'h7} : {aa, wd, 3'h0};
    {ra, arv, rr} <= w ? {ra, 2'h0} : {a, 2'h3};
    fin = 1'b0;
    for (n = 0; n < 100 && !fin; n++)
    begin
      @(negedge clk);
      ta = w ? awv && awr : arv && arr;
      tw = wv && wr;
      fin = w ? bv : rv;
      got = rd;
      resp = w ? bresp : rresp;
      @(posedge clk);
      if (ta && w)
        awv <= 1'b0;
      if (ta && !w)
        arv <= 1'b0;
      if (tw)
        wv <= 1'b0;
    end
    if (!fin)
      n_errors++;
    br <= 1'b0;
    rr <= 1'b0;
  endtask : ax
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ax(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, got)
  endtask : rdchk
  function automatic logic [31:0] blk(input logic [4:0] punwl, input logic [3:0] rn, input logic [7:0] imm);
    return {4'he, 3'h6, punwl, rn, 4'h2, 4'h1, imm};
  endfunction : blk
  function automatic logic [31:0] rg(input logic l, input logic [3:0] rdn);
    return {8'hee, 3'h0, l, 4'h5, rdn, 8'h11, 4'h6};
  endfunction : rg
  task automatic run(input logic [31:0] i);
    int n;
    ax(1'b1, CTU_OFS_STATUS, 32'h0000_001e);
    ax(1'b1, CTU_OFS_INSTR, i);
    n_n = 0;
    n_s = 0;
    ax(1'b1, CTU_OFS_CTRL, 32'h0000_0001);
    got = 32'h0000_0000;
    for (n = 0; n < 50 && got[CTU_ST_DONE] !== 1'b1; n++)
      ax(1'b0, CTU_OFS_STATUS, 32'h0000_0000);
    if (got[CTU_ST_DONE] !== 1'b1)
      n_errors++;
  endtask : run
  // ==========
  // scenarios
  task automatic t_pre;
    ax(1'b1, CTU_OFS_BASE, 32'h0000_0101);
    blen <= 4'h2;
    llen <= 4'h3;
    run(blk(5'h1e, 4'h3, 8'h03));
    `CHK("first addr", 32'h0000_010d, fa)
    `CHK("s cycles", 2, n_s)
    `CHK("n cycles", 2, n_n)
    rdchk("base", CTU_OFS_BASE, 32'h0000_010d);
    rdchk("words", CTU_OFS_WORDS, 32'h0000_0003);
    $display("t_pre done");
  endtask : t_pre
  task automatic t_post_pc;
    blen <= 4'h0;
    run(blk(5'h09, 4'hf, 8'h02));
    `CHK("pc post addr", 32'h0000_0048, fa)
    `CHK("short len", 0, n_s)
    rdchk("base kept", CTU_OFS_BASE, 32'h0000_010d);
    $display("t_post_pc done");
  endtask : t_post_pc
  task automatic t_abort;
    ax(1'b1, CTU_OFS_BASE, 32'h0000_0300);
    abt <= 1'b1;
    run(blk(5'h0e, 4'h3, 8'h04));
    abt <= 1'b0;
    `CHK("abort flag", 1'b1, got[CTU_ST_ABORT])
    `CHK("abort stop", 0, n_s)
    rdchk("abort wb", CTU_OFS_BASE, 32'h0000_0310);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_skip;
    run(blk(5'h1e, 4'h3, 8'h01) & 32'h0fff_ffff);
    `CHK("skip flag", 1'b1, got[CTU_ST_SKIP])
    `CHK("skip no bus", 0, n_n)
    rdchk("skip base", CTU_OFS_BASE, 32'h0000_0310);
    $display("t_skip done");
  endtask : t_skip
  task automatic t_absent;
    run(blk(5'h1e, 4'h3, 8'h01) | 32'h0000_0400);
    `CHK("absent flag", 1'b1, got[CTU_ST_ABSENT])
    `CHK("absent no bus", 0, n_n)
    ax(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped", CTU_RESP_SLVERR, resp)
    ax(1'b1, 8'h40, 32'h0000_0000);
    `CHK("unmapped wr", CTU_RESP_SLVERR, resp)
    $display("t_absent done");
  endtask : t_absent
  task automatic t_moves;
    reply <= 32'ha000_0000;
    run(rg(1'b1, 4'hf));
    rdchk("flags", CTU_OFS_FLAGS, 32'h0000_000a);
    run(rg(1'b0, 4'hf));
    `CHK("pc source", 32'h0000_004c, cw)
    ax(1'b1, CTU_OFS_SRC, 32'h1234_5678);
    run(rg(1'b0, 4'h3));
    `CHK("src word", 32'h1234_5678, cw)
    $display("t_moves done");
  endtask : t_moves
  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    reset_n = 1'b0;
    {awv, wv, br, arv, rr, abt, aa, ra, wd, reply, blen} = '0;
    llen = 4'h1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    ax(1'b1, CTU_OFS_PC, 32'h0000_0040);
    t_pre();
    t_post_pc();
    t_abort();
    t_skip();
    t_absent();
    t_moves();
    wrap_up();
  end
endmodule : tb_top
bind ctu_top ctu_props chk (.*);
`default_nettype wire
